// File: mtio_consts.svh
// Offsets, field positions, reset values and timing counts of the timer block
`ifndef MTIO_CONSTS_SVH
`define MTIO_CONSTS_SVH
`define MTIO_NCH 6
`define MTIO_A_VAL 5'h00
`define MTIO_A_CLK 5'h06
`define MTIO_A_MODE 5'h08
`define MTIO_A_RCLR 5'h10
`define MTIO_GRP_VAL 2'h0
`define MTIO_GRP_MODE 2'h1
`define MTIO_GRP_RCLR 2'h2
`define MTIO_CLK_BASE_BIT 0
`define MTIO_CLK_DIV_LSB 8
`define MTIO_MODE_LSB 16
`define MTIO_EDGE_SEL_BIT 8
`define MTIO_CLK_RST 16'h0100
`define MTIO_SYS_CLK_KHZ 25000
`define MTIO_SYS_TICK_KHZ 750
`define MTIO_DEB_MS 87
`define MTIO_DUTY_LOW 32'hFFFF_0000
`define MTIO_DUTY_HIGH 32'h0000_FFFF
`endif

// File: mtio_pkg.sv
// Types shared by the timer block
package mtio_pkg;
  typedef enum logic [3:0] {
    MTIO_PWM16 = 4'h0,
    MTIO_PWM8 = 4'h1,
    MTIO_PER32R = 4'h2,
    MTIO_PER32F = 4'h3,
    MTIO_DUTY = 4'h4,
    MTIO_CNT = 4'h5,
    MTIO_CNTDB = 4'h6,
    MTIO_FOUT = 4'h7,
    MTIO_QUAD = 4'h8,
    MTIO_TSTOP = 4'h9,
    MTIO_SYSLO = 4'hA,
    MTIO_SYSHI = 4'hB,
    MTIO_PER16R = 4'hC,
    MTIO_PER16F = 4'hD
  } mtio_mode_t;
  typedef struct packed {
    logic [4:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } mtio_req_t;
endpackage

// File: mtio_top.sv
// Multi-mode timer channels: capture, counting, frequency out, quadrature
//
// Overview of operation
// RL1: Modes 2/3 capture edge-to-edge period, 32 bits
// RL2: Zero write clears capture or counting channel
// RL3: Read-and-clear returns the value before clearing
// RL4: Mode 4 result: low half high-time, upper low-time
// RL5: Each edge refreshes its duty half
// RL6: Duty clear loads 0/65535 or 65535/0 by level
// RL7: Mode 5 counts rising edges, 32 bits
// RL8: Debounce hold-off is count times 87 ms
// RL9: High byte bit 0 picks counted edge
// RL10: Count then ignore edges until hold-off ends
// RL11: Debounce config value never clears; updates leave it
// RL12: Mode 7 square wave, clock over 2 times value
// RL13: Frequency output starts at timer clock roll
// RL14: Quadrature pair, 4x, shared signed count
// RL15: Zero to either pair channel clears both
// RL16: Mode 9 counts rises, halts even at stop
// RL17: Stop count saturates; reconfig or rewrite resumes
// RL18: Halted even channel releases its line
// RL19: Free 64-bit 750 kHz counter, modes 10/11
// RL20: Modes 12/13 give exact 16-bit periods
// RL21: Outputs restart only on global reconfiguration
// RL22: Sources keep total edge rate within limits
// RL23: Timer clock is base over 8-bit divisor
// RL24: Inputs synchronised before edge detection
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`include "mtio_consts.svh"
module mtio_top
  import mtio_pkg::*;
#(
  parameter logic [16:0] DEB_TICKS = 17'(`MTIO_DEB_MS * `MTIO_SYS_TICK_KHZ)
)
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire mtio_req_t BUS,
  output logic [31:0] RDATA,
  input wire logic [5:0] FLEX_IO_I,
  output logic [5:0] FLEX_IO_O,
  output logic [5:0] FLEX_IO_OE
);
  localparam int NCH = `MTIO_NCH;

  // Bus decode
  wire [1:0] grp = BUS.addr[4:3];
  wire [2:0] ch = BUS.addr[2:0];
  wire ch_ok = ch < 3'(NCH);
  wire wr_val = BUS.wr && grp == `MTIO_GRP_VAL && ch_ok;
  wire wr_mode = BUS.wr && grp == `MTIO_GRP_MODE && ch_ok;
  wire wr_clk = BUS.wr && BUS.addr == `MTIO_A_CLK;
  wire rd_clr = BUS.rd && grp == `MTIO_GRP_RCLR && ch_ok;
  // Any mode or clock write re-initialises every channel
  wire reconf = wr_mode || wr_clk;
  wire wzero = BUS.wdata == 32'h0000_0000;

  logic [15:0] clk_cfg;
  logic [14:0] acc;
  logic [7:0] dcnt;
  logic [63:0] sys_cnt;
  logic [16:0] deb_cnt;
  logic [5:0] s1;
  logic [5:0] s2;
  logic [5:0] s3;
  logic [6:0] stop;
  logic [31:0] res_w [NCH];
  logic [3:0] md_w [NCH];
  logic [15:0] val_w [NCH];

  // 750 kHz tick from a fractional accumulator, exact on average
  wire [15:0] acc_sum = {1'b0, acc} + 16'(`MTIO_SYS_TICK_KHZ);
  wire sys_tick = acc_sum >= 16'(`MTIO_SYS_CLK_KHZ);
  wire [14:0] next_acc = sys_tick ? 15'(acc_sum - 16'(`MTIO_SYS_CLK_KHZ)) : acc_sum[14:0];
  // The fast base is capped at one tick per system clock
  wire base_tick = clk_cfg[`MTIO_CLK_BASE_BIT] ? 1'b1 : sys_tick;
  wire [7:0] div = clk_cfg[`MTIO_CLK_DIV_LSB +: 8];
  // RL23: divisor roll
  wire tick = base_tick && (dcnt == div - 8'h01);
  wire deb_stb = sys_tick && (deb_cnt == DEB_TICKS - 17'h0_0001);
  wire [5:0] rise = s2 & ~s3;
  wire [5:0] fall = ~s2 & s3;
  assign stop[6] = 1'b0;

  // Shared clocking: configuration, timer clock divider, system counter
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      clk_cfg <= `MTIO_CLK_RST;
      acc <= 15'h0000;
      dcnt <= 8'h00;
      sys_cnt <= 64'h0000_0000_0000_0000;
      deb_cnt <= 17'h0_0000;
    end
    else if (CE)
    begin
      acc <= next_acc;
      // Kept in the register's own layout so readback needs no repacking;
      // bits 7:1 always read as zero
      if (wr_clk)
        clk_cfg <= {BUS.wdata[`MTIO_CLK_DIV_LSB +: 8], 7'h00, BUS.wdata[`MTIO_CLK_BASE_BIT]};
      // RL23: divide base by divisor, zero meaning 256
      if (reconf)
        dcnt <= 8'h00;
      else if (tick)
        dcnt <= 8'h00;
      else if (base_tick)
        dcnt <= dcnt + 8'h01;
      // RL19: free running, never reset by reconfiguration
      if (sys_tick)
        sys_cnt <= sys_cnt + 64'h0000_0000_0000_0001;
      // Hold-off unit runs free, which gives the up-to-one-unit jitter
      if (deb_stb)
        deb_cnt <= 17'h0_0000;
      else if (sys_tick)
        deb_cnt <= deb_cnt + 17'h0_0001;
    end
  end

  // RL24: two-stage synchroniser, then a third stage for edges
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      s1 <= 6'h3F;
      s2 <= 6'h3F;
      s3 <= 6'h3F;
    end
    else if (CE)
    begin
      s1 <= FLEX_IO_I;
      s2 <= s1;
      s3 <= s2;
    end
  end

  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    localparam logic [2:0] ID = 3'(g);
    localparam int PAIR = g | 1;
    logic [31:0] res;
    logic [31:0] cnt;
    logic [15:0] val;
    mtio_mode_t md;
    logic [7:0] hold;
    logic armed;
    logic run;
    logic out;
    logic oe;
    logic [1:0] qab;
    wire sel = ch == ID;
    wire even = (g % 2) == 0;
    // RL15: a zero to either channel of a quadrature pair clears both
    wire pair_hit = md == MTIO_QUAD && even && ch == 3'(PAIR);
    // RL2: zero write, or read-and-clear of this channel
    wire clr = (sel || pair_hit) && ((wr_val && wzero) || rd_clr);
    // RL11: mode 6 and 8 keep their configured value on updates
    wire upd = wr_val && sel && md != MTIO_CNTDB && md != MTIO_QUAD;
    // RL18: halted by the odd neighbour's stop match
    wire halted = even && stop[g + 1];
    wire [1:0] qcur = {s2[g], s2[PAIR]};
    wire qstep = qcur != qab && (qcur ^ qab) != 2'b11;
    wire qup = qab[1] ^ qcur[0];
    // RL9: edge select, set picks rising
    wire db_edge = val[`MTIO_EDGE_SEL_BIT] ? rise[g] : fall[g];
    // RL16: match with a non-zero stop value on an odd channel
    assign stop[g] = !even && md == MTIO_TSTOP && val != 16'h0000 && res[15:0] == val;
    assign res_w[g] = res;
    assign md_w[g] = md;
    assign val_w[g] = val;
    assign FLEX_IO_O[g] = out;
    assign FLEX_IO_OE[g] = oe;

    // Per-channel engine
    always_ff @(posedge CLK or negedge RST_B)
    begin
      if (!RST_B)
      begin
        md <= MTIO_PWM16;
        val <= 16'h0000;
        res <= 32'h0000_0000;
        cnt <= 32'h0000_0000;
        hold <= 8'h00;
        armed <= 1'b1;
        run <= 1'b0;
        out <= 1'b0;
        oe <= 1'b0;
        qab <= 2'b00;
      end
      else if (CE)
      begin
        if (reconf)
        begin
          // RL21: reconfiguration stops and restarts all outputs
          if (wr_mode && sel)
          begin
            md <= mtio_mode_t'(BUS.wdata[`MTIO_MODE_LSB +: 4]);
            // RL8: low byte is the hold-off count in config
            val <= BUS.wdata[15:0];
          end
          res <= 32'h0000_0000;
          cnt <= 32'h0000_0000;
          hold <= 8'h00;
          armed <= 1'b1;
          run <= 1'b0;
          out <= 1'b0;
          oe <= 1'b0;
          qab <= qcur;
        end
        else if (clr)
        begin
          cnt <= 32'h0000_0000;
          // RL6: duty clear reflects the present level
          if (md == MTIO_DUTY)
            res <= s2[g] ? `MTIO_DUTY_HIGH : `MTIO_DUTY_LOW;
          else
            res <= 32'h0000_0000;
        end
        else
        begin
          if (upd)
          begin
            val <= BUS.wdata[15:0];
            // RL17: rewriting the stop value resumes the even channel
            if (md == MTIO_TSTOP)
              res <= 32'h0000_0000;
          end
          qab <= qcur;
          // RL18: a halted channel lets go of its line
          oe <= md == MTIO_FOUT && run && !halted;
          case (md)
            MTIO_PER32R, MTIO_PER32F, MTIO_PER16R, MTIO_PER16F:
            begin
              // RL1: capture ticks since previous chosen edge
              if ((md[0] == 1'b0 && rise[g]) || (md[0] == 1'b1 && fall[g]))
              begin
                // RL20: short modes keep the exact low 16 bits
                res <= md[3] ? {16'h0000, cnt[15:0]} : cnt;
                cnt <= 32'h0000_0000;
              end
              else if (tick)
                cnt <= cnt + 32'h0000_0001;
            end
            MTIO_DUTY:
            begin
              // RL4: rising edge ends a low span, falling a high one
              // RL5: each edge refreshes its own half
              if (rise[g])
              begin
                res[31:16] <= cnt[15:0];
                cnt <= 32'h0000_0000;
              end
              else if (fall[g])
              begin
                res[15:0] <= cnt[15:0];
                cnt <= 32'h0000_0000;
              end
              else if (tick)
                cnt <= cnt + 32'h0000_0001;
            end
            MTIO_CNT:
            begin
              // RL7: rising edge count
              if (rise[g])
                res <= res + 32'h0000_0001;
            end
            MTIO_CNTDB:
            begin
              // RL10: count once, then wait out the hold-off
              if (armed && db_edge)
              begin
                res <= res + 32'h0000_0001;
                armed <= 1'b0;
                hold <= val[7:0];
              end
              else if (!armed && deb_stb)
              begin
                if (hold == 8'h00)
                  armed <= 1'b1;
                else
                  hold <= hold - 8'h01;
              end
            end
            MTIO_FOUT:
            begin
              // RL13: start on the timer clock roll
              // RL12: toggle every value ticks, zero meaning 256
              if (tick && !halted)
              begin
                run <= 1'b1;
                if (run && cnt[7:0] == val[7:0] - 8'h01)
                begin
                  out <= !out;
                  cnt <= 32'h0000_0000;
                end
                else if (run)
                  cnt <= cnt + 32'h0000_0001;
              end
            end
            MTIO_QUAD:
            begin
              // RL14: even channel holds the signed 4x count
              if (even && qstep)
                res <= qup ? res + 32'h0000_0001 : res - 32'h0000_0001;
            end
            MTIO_TSTOP:
            begin
              // RL17: count saturates at the stop value
              if (!even && rise[g] && res[15:0] != val)
                res <= {16'h0000, res[15:0] + 16'h0001};
            end
            default:
            begin
              cnt <= cnt;
            end
          endcase
        end
      end
    end
  end

  // Read selection; odd quadrature channel mirrors its even partner
  wire [2:0] rch = (md_w[ch] == MTIO_QUAD && ch[0]) ? ch - 3'h1 : ch;
  wire [3:0] rmd = md_w[ch];
  // RL19: modes 10 and 11 read the system counter halves
  wire [31:0] val_rd = rmd == MTIO_SYSLO ? sys_cnt[31:0] :
                       rmd == MTIO_SYSHI ? sys_cnt[63:32] : res_w[rch];
  wire [31:0] rd_mux = (grp == `MTIO_GRP_VAL || grp == `MTIO_GRP_RCLR) && ch_ok ? val_rd :
                       grp == `MTIO_GRP_MODE && ch_ok ? {12'h000, rmd, val_w[ch]} :
                       BUS.addr == `MTIO_A_CLK ? {16'h0000, clk_cfg} : 32'h0000_0000;

  // RL3: data registered in the clearing cycle is the old value
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      RDATA <= 32'h0000_0000;
    else if (CE)
      RDATA <= BUS.rd ? rd_mux : 32'h0000_0000;
  end
endmodule // mtio_top

// File: mtio_top_asserts.sv
// Port-level assertions for the timer block
`timescale 1ns/1ns
module mtio_top_asserts
  import mtio_pkg::*;
#(
  parameter logic [16:0] DEB_TICKS = 17'h0_FEE2
)
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire mtio_req_t BUS,
  input wire logic [31:0] RDATA,
  input wire logic [5:0] FLEX_IO_I,
  input wire logic [5:0] FLEX_IO_O,
  input wire logic [5:0] FLEX_IO_OE
);
  logic [3:0] mode0;
  // Shadow of the channel 0 mode, so drive rights can be judged
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      mode0 <= 4'h0;
    else if (CE && BUS.wr && BUS.addr == 5'h08)
      mode0 <= BUS.wdata[19:16];
  end
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  // Read port: data only in the answer cycle, zero elsewhere
  rd_idle_a:
    assert property (CE && !BUS.rd ##1 CE |-> RDATA == 32'h0000_0000)
    else $error("stray read data");
  wr_quiet_a:
    assert property (CE && BUS.wr |=> RDATA == 32'h0000_0000)
    else $error("write produced read data");
  unmapped_a:
    assert property (CE && BUS.rd && (BUS.addr > 5'h15 || BUS.addr == 5'h07)
      |=> RDATA == 32'h0000_0000)
    else $error("unmapped read not zero");
  mode_rb_a:
    assert property (CE && BUS.wr && BUS.addr[4:3] == 2'b01 && BUS.addr[2:0] < 3'h6
      ##1 CE && !BUS.wr ##1 CE && BUS.rd && BUS.addr == $past(BUS.addr, 2)
      |=> RDATA == {12'h000, $past(BUS.wdata[19:0], 3)})
    else $error("mode readback wrong");
  b2b_rd_a:
    assert property (CE && BUS.rd && BUS.addr[4:3] == 2'b01 ##1 CE && BUS.rd && $stable(BUS.addr)
      |=> $stable(RDATA))
    else $error("back to back reads differ");
  // Outputs: quiet after reset, frozen without enable, line 0 driven only in mode 7
  reset_out_a:
    assert property ($rose(RST_B) |-> RDATA == 32'h0000_0000 && FLEX_IO_OE == 6'h00)
    else $error("outputs active after reset");
  freeze_a:
    assert property (!CE |=> $stable(RDATA) && $stable(FLEX_IO_O) && $stable(FLEX_IO_OE))
    else $error("outputs moved while disabled");
  oe_mode_a:
    assert property (mode0 != 4'h7 ##1 mode0 != 4'h7 |-> !FLEX_IO_OE[0])
    else $error("line 0 driven outside mode 7");
  cover property (mode0 == 4'h7 && FLEX_IO_OE[0]);
  cover property (CE && BUS.rd && BUS.addr[4]);
  cover property (!CE);
endmodule // mtio_top_asserts
bind mtio_top mtio_top_asserts #(.DEB_TICKS(DEB_TICKS)) u_chk (.CLK(CLK), .RST_B(RST_B),
  .CE(CE), .BUS(BUS), .RDATA(RDATA), .FLEX_IO_I(FLEX_IO_I), .FLEX_IO_O(FLEX_IO_O),
  .FLEX_IO_OE(FLEX_IO_OE));

// File: mtio_src.sv
// External signal sources on the six lines, idle high like pull-ups
`timescale 1ns/1ns
module mtio_src
(
  input wire logic clk,
  output logic [5:0] lvl
);
  // Edge spacing of 250 cycles keeps one line under 100,000 edges a second
  localparam int GAP = 250;
  initial lvl = 6'h3F;
  task automatic set(input int ch, input logic v, input int hold);
    @(posedge clk);
    lvl[ch] <= v;
    repeat ((hold < GAP) ? GAP : hold) @(posedge clk);
  endtask
  task automatic pulse(input int ch);
    set(ch, 1'b0, GAP);
    set(ch, 1'b1, GAP);
  endtask
endmodule // mtio_src

// File: mtio_top_test.sv
// Self-checking bench for the timer block
`timescale 1ns/1ns
module mtio_top_test
  import mtio_pkg::*;
;
  logic clk;
  logic rst_b;
  logic ce;
  mtio_req_t bus;
  logic [31:0] rdata;
  logic [31:0] q;
  logic [5:0] fio_i, fio_o, fio_oe, lvl;
  int errors = 0;
  int n_checks = 0;
  // Short hold-off unit keeps the debounce run brief
  mtio_top #(.DEB_TICKS(17'h0_0014)) dut (.CLK(clk), .RST_B(rst_b), .CE(ce), .BUS(bus),
    .RDATA(rdata), .FLEX_IO_I(fio_i), .FLEX_IO_O(fio_o), .FLEX_IO_OE(fio_oe));
  mtio_src src (.clk(clk), .lvl(lvl));
  // A driven line shows the block's level, otherwise the source's
  assign fio_i = (fio_oe & fio_o) | (~fio_oe & lvl);
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [15:0] got, input int lo, input int hi);
    n_checks++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h min=%h", $time, got, lo[15:0]);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  // One-cycle read; the answer is taken in the cycle after the strobe
  task automatic rdq(input logic [4:0] a);
    @(posedge clk);
    bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 q = rdata;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    rdq(a);
    chk(q, exp);
  endtask
  task automatic oe_on(input int ch);
    int n;
    for (n = 0; n < 40 && fio_oe[ch] !== 1'b1; n++)
      @(posedge clk) #1;
    chk({31'h0, fio_oe[ch]}, 32'h0000_0001);
  endtask
  task automatic t_map();
    rd(5'h08, 32'h0000_0000);
    rd(5'h1F, 32'h0000_0000);
    wr(5'h09, 32'h0005_1234);
    // Three back-to-back reads; each answer stands for one cycle only
    @(posedge clk);
    bus <= '{5'h09, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clk);
    @(posedge clk);
    bus.addr <= 5'h1F;
    #1 chk(rdata, 32'h0005_1234);
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk(rdata, 32'h0000_0000);
    $display("map test done");
  endtask
  task automatic t_count();
    wr(5'h08, 32'h0005_0000);
    rd(5'h08, 32'h0005_0000);
    repeat (3) src.pulse(0);
    rd(5'h00, 32'h0000_0003);
    @(posedge clk);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    rd(5'h10, 32'h0000_0003);
    rd(5'h00, 32'h0000_0000);
    src.pulse(0);
    rd(5'h00, 32'h0000_0001);
    wr(5'h00, 32'h0000_0000);
    rd(5'h00, 32'h0000_0000);
    $display("count test done");
  endtask
  task automatic t_deb();
    wr(5'h09, 32'h0006_0101);
    src.set(1, 1'b0, 250);
    rd(5'h01, 32'h0000_0000);
    src.set(1, 1'b1, 250);
    src.pulse(1);
    rd(5'h01, 32'h0000_0001);
    repeat (1500) @(posedge clk);
    src.pulse(1);
    rd(5'h01, 32'h0000_0002);
    wr(5'h01, 32'h0000_0000);
    rd(5'h01, 32'h0000_0000);
    $display("debounce test done");
  endtask
  task automatic t_duty();
    wr(5'h06, 32'h0000_0101);
    rd(5'h06, 32'h0000_0101);
    wr(5'h0A, 32'h0004_0000);
    wr(5'h02, 32'h0000_0000);
    rd(5'h02, 32'h0000_FFFF);
    src.set(2, 1'b0, 500);
    src.set(2, 1'b1, 250);
    src.set(2, 1'b0, 250);
    rd(5'h1E, 32'h0000_0000);
    rdq(5'h02);
    rc(q[15:0], 249, 251);
    rc(q[31:16], 499, 501);
    rc(q[15:0] + q[31:16], 748, 752);
    wr(5'h02, 32'h0000_0000);
    rd(5'h02, 32'hFFFF_0000);
    $display("duty test done");
  endtask
  task automatic t_fout();
    int n;
    logic v;
    wr(5'h0B, 32'h0007_0004);
    oe_on(3);
    v = fio_o[3];
    for (n = 0; n < 20 && fio_o[3] === v; n++)
      @(posedge clk) #1;
    v = fio_o[3];
    for (n = 0; n < 20 && fio_o[3] === v; n++)
      @(posedge clk) #1;
    chk(32'(n), 32'h0000_0004);
    $display("frequency test done");
  endtask
  task automatic t_quad();
    wr(5'h0C, 32'h0008_0000);
    wr(5'h0D, 32'h0008_0000);
    src.set(4, 1'b0, 250);
    src.set(5, 1'b0, 250);
    src.set(4, 1'b1, 250);
    src.set(5, 1'b1, 250);
    wr(5'h04, 32'h0000_0005);
    rd(5'h04, 32'hFFFF_FFFC);
    rd(5'h05, 32'hFFFF_FFFC);
    wr(5'h05, 32'h0000_0000);
    rd(5'h04, 32'h0000_0000);
    $display("quadrature test done");
  endtask
  task automatic t_stop();
    wr(5'h08, 32'h0007_0001);
    wr(5'h09, 32'h0009_0002);
    oe_on(0);
    repeat (3) src.pulse(1);
    rd(5'h01, 32'h0000_0002);
    chk({31'h0, fio_oe[0]}, 32'h0000_0000);
    wr(5'h01, 32'h0000_0002);
    oe_on(0);
    $display("stop test done");
  endtask
  // Period capture on both edges and both widths, then the system counter
  task automatic t_period();
    logic [31:0] v;
    wr(5'h0A, 32'h0002_0000);
    src.set(2, 1'b1, 300);
    src.set(2, 1'b0, 250);
    src.set(2, 1'b1, 300);
    rdq(5'h02);
    rc(q[15:0], 550, 552);
    wr(5'h0A, 32'h000D_0000);
    src.set(2, 1'b0, 300);
    src.set(2, 1'b1, 250);
    src.set(2, 1'b0, 300);
    rdq(5'h02);
    rc(q[15:0], 550, 552);
    chk({16'h0000, q[31:16]}, 32'h0000_0000);
    wr(5'h0B, 32'h000A_0000);
    wr(5'h0C, 32'h000B_0000);
    rdq(5'h03);
    v = q;
    repeat (998) @(posedge clk);
    rdq(5'h03);
    rc(16'(q - v), 29, 31);
    rd(5'h04, 32'h0000_0000);
    $display("period test done");
  endtask
  // Mid-run reset while a line is driven
  task automatic t_reset();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    #1 chk({26'h0, fio_oe}, 32'h0000_0000);
    rd(5'h08, 32'h0000_0000);
    rd(5'h06, 32'h0000_0100);
    $display("reset test done");
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Main sequence after a six-cycle reset
  initial
  begin
    rst_b = 1'b0;
    ce = 1'b1;
    bus = '0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_map();
    t_count();
    t_deb();
    t_duty();
    t_period();
    t_fout();
    t_quad();
    t_stop();
    t_reset();
    tally_and_finish();
  end
  // Cut a hang at about four times the expected run
  initial
  begin
    #2_000_000;
    errors++;
    tally_and_finish();
  end
endmodule // mtio_top_test
